/* hdl/smc_pkg.sv */
// Package: sleep-mode controller constants and types
package smc_pkg;

	// ---------------------------------------------------------------
	// Sleep mode select codes
	// ---------------------------------------------------------------
	localparam logic [2:0] SMC_MODE_IDLE    = 3'h0;
	localparam logic [2:0] SMC_MODE_ADCNR   = 3'h1;
	localparam logic [2:0] SMC_MODE_PDOWN   = 3'h2;
	localparam logic [2:0] SMC_MODE_PSAVE   = 3'h3;
	localparam logic [2:0] SMC_MODE_RSVD4   = 3'h4;
	localparam logic [2:0] SMC_MODE_RSVD5   = 3'h5;
	localparam logic [2:0] SMC_MODE_STANDBY = 3'h6;
	localparam logic [2:0] SMC_MODE_XSTBY   = 3'h7;

	// ---------------------------------------------------------------
	// Control register field positions and reset values
	// ---------------------------------------------------------------
	localparam int         SMC_BROWNOUT_SLEEP_DISABLE_BIT       = 6;
	localparam int         SMC_BROWNOUT_DISABLE_UNLOCK_BIT      = 5;
	localparam logic       SMC_BROWNOUT_SLEEP_DISABLE_RESET     = 1'b0;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int         SMC_CLK_MHZ        = 10;
	localparam int         SMC_IRQ_HOLD_CYC   = 4;
	localparam int         SMC_STBY_WAKE_CYC  = 6;
	localparam int         SMC_UNLOCK_CYC     = 4;
	localparam int         SMC_BROWNOUT_SLEEP_DISABLE_DELAY_CYC = 3;
	localparam int         SMC_BROWNOUT_SLEEP_DISABLE_LIFE_CYC  = 3;
	localparam int         SMC_BOD_WAKE_US    = 60;
	localparam int         SMC_BOD_WAKE_CYC   = SMC_BOD_WAKE_US * SMC_CLK_MHZ;
	localparam int         SMC_CNT_W          = 16;

	// ---------------------------------------------------------------
	// Sequencer states
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		SMC_RUN   = 4'h1,
		SMC_SLEEP = 4'h2,
		SMC_WAKE  = 4'h4,
		SMC_HOLD  = 4'h8
	} smc_state_t;

endpackage

/* hdl/smc_sleep_ctrl.sv */
// Sleep-mode controller: mode entry, clock gating, wake qualification, brown-out disable
//------------------------------------------------------------------
// Summary of operation
// - Sleep only with enable bit and halt
// - Interrupt wake holds core four extra cycles
// - Register file and SRAM never cleared here
// - Reset during sleep restarts at reset vector
// - Code 000 Idle stops CPU and flash
// - Idle/noise mode starts enabled converter
// - Code 001 noise mode stops IO clock
// - Noise mode wake sources limited list
// - Code 010 Power-down stops all clocks
// - Power-down wake sources limited list
// - Power-down wake waits fuse start-up time
// - Code 011 Power-save keeps timer 2
// - Timer 2 wake needs mask and global enable
// - Power-save stops unused timer 2 clocks
// - Code 110 Standby, oscillator on, six cycles
// - Brown-out off in sleep, back on wake
// - Brown-out disabled wake lasts 60 us
// - Disable bit six, reset zero
// - Brown-out disable only deep modes
// - Extended Standby keeps main clock, async timer
// - Deep modes wake pins by level only
// - Code 111 Extended Standby, six cycles
// - Disable bit active three, clears three later
// - Codes 100 and 101 reserved
//------------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none
module smc_sleep_ctrl
	import smc_pkg::*;
#(
	parameter int CNT_W = SMC_CNT_W
) (
	// Clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_reset_n,
	// Core control
	input  wire logic             i_halt_exec,
	input  wire logic             i_sleep_enable_bit,
	input  wire logic [2:0]       i_sleep_mode_select,
	input  wire logic             i_core_reset,
	// Brown-out control register write
	input  wire logic             i_mcu_control_register_wr,
	input  wire logic             i_brownout_sleep_disable,
	input  wire logic             i_brownout_disable_unlock,
	// Configuration
	input  wire logic             i_ext_crystal,
	input  wire logic [CNT_W-1:0] i_startup_cycles,
	input  wire logic             i_adc_enable,
	input  wire logic             i_t2_enable,
	input  wire logic             i_t2_async,
	input  wire logic             i_global_irq_enable,
	input  wire logic [1:0]       i_timer2_irq_mask,
	// Wake sources (pins are asynchronous)
	input  wire logic             i_external_irq_zero,
	input  wire logic             i_external_irq_one,
	input  wire logic [1:0]       i_ext_irq_level_mode,
	input  wire logic             i_pin_change,
	input  wire logic             i_twi_match,
	input  wire logic             i_wdt_irq,
	input  wire logic             i_adc_done,
	input  wire logic             i_spm_ready,
	input  wire logic [1:0]       i_timer2_event,
	input  wire logic             i_other_irq,
	// Status and gating outputs
	output var  logic             o_sleeping,
	output var  logic             o_core_hold,
	output var  logic             o_clk_cpu_en,
	output var  logic             o_clk_flash_en,
	output var  logic             o_clk_io_en,
	output var  logic             o_clk_adc_en,
	output var  logic             o_async_timer_clock_en,
	output var  logic             o_main_osc_en,
	output var  logic             o_timer_osc_en,
	output var  logic             o_brownout_detector_en,
	output var  logic             o_brownout_sleep_disable,
	output var  logic             o_adc_start,
	output var  logic             o_resume_irq,
	output var  logic             o_reset_vector
);
	smc_state_t       state;
	logic [2:0]       mode;
	logic [CNT_W-1:0] cnt;
	logic             bod_off;
	logic [2:0]       unlock_cnt;
	logic [2:0]       brownout_sleep_disable_age;
	logic             brownout_sleep_disable_set;
	logic             brownout_sleep_disable_active;
	logic             wake_req;
	logic             deep;
	logic             valid_mode;
	logic [1:0]       ext_pin_s;
	logic [CNT_W-1:0] wake_len;
	logic [CNT_W-1:0] next_cnt;

	// ---------------------------------------------------------------
	// Pin input synchroniser
	// ---------------------------------------------------------------
	smc_sync #(.W(2)) u_sync (
		.i_clk     (i_clk),
		.i_reset_n (i_reset_n),
		.i_async   ({i_external_irq_one, i_external_irq_zero}),
		.o_sync    (ext_pin_s)
	);

	// ---------------------------------------------------------------
	// Mode decode
	// ---------------------------------------------------------------
	// Standby codes need a crystal; reserved codes never sleep
	always_comb begin
		unique case (i_sleep_mode_select)
			SMC_MODE_IDLE, SMC_MODE_ADCNR,
			SMC_MODE_PDOWN, SMC_MODE_PSAVE: valid_mode = 1'b1;
			SMC_MODE_STANDBY, SMC_MODE_XSTBY: valid_mode = i_ext_crystal;
			SMC_MODE_RSVD4, SMC_MODE_RSVD5: valid_mode = 1'b0;
		endcase
	end

	assign deep = (mode != SMC_MODE_IDLE) && (mode != SMC_MODE_ADCNR);

	// Wake qualification per mode
	always_comb begin
		logic lvl_wake;
		logic t2_wake;
		lvl_wake = (ext_pin_s[0] & i_ext_irq_level_mode[0])
			| (ext_pin_s[1] & i_ext_irq_level_mode[1]);
		t2_wake  = i_global_irq_enable
			& |(i_timer2_event & i_timer2_irq_mask) & i_t2_enable;
		wake_req = 1'b0;
		unique case (mode)
			SMC_MODE_IDLE:
				wake_req = |ext_pin_s | i_pin_change | i_twi_match | i_wdt_irq
					| i_adc_done | i_spm_ready | t2_wake | i_other_irq;
			SMC_MODE_ADCNR:
				wake_req = i_adc_done | i_wdt_irq | i_twi_match | i_spm_ready
					| (t2_wake & i_t2_async) | lvl_wake | i_pin_change;
			SMC_MODE_PDOWN, SMC_MODE_STANDBY:
				wake_req = i_wdt_irq | i_twi_match | lvl_wake | i_pin_change;
			SMC_MODE_PSAVE:
				wake_req = i_wdt_irq | i_twi_match | lvl_wake | i_pin_change | t2_wake;
			SMC_MODE_XSTBY:
				wake_req = i_wdt_irq | i_twi_match | lvl_wake | i_pin_change
					| (t2_wake & i_t2_async);
			default: wake_req = 1'b0;
		endcase
	end

	// Wake delay: fuse start-up, six cycles for standby, longer if detector was off
	always_comb begin
		if (mode == SMC_MODE_STANDBY || mode == SMC_MODE_XSTBY) begin
			wake_len = CNT_W'(SMC_STBY_WAKE_CYC);
		end else if (deep) begin
			wake_len = i_startup_cycles;
		end else begin
			wake_len = CNT_W'(1);
		end
		if (bod_off && wake_len < CNT_W'(SMC_BOD_WAKE_CYC)) begin
			wake_len = CNT_W'(SMC_BOD_WAKE_CYC);
		end
	end

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	// Core reset overrides everything and leaves contents alone
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state <= SMC_RUN;
			mode  <= SMC_MODE_IDLE;
		end else if (i_core_reset) begin
			state <= SMC_RUN;
		end else begin
			unique case (state)
				SMC_RUN: begin
					if (i_halt_exec && i_sleep_enable_bit && valid_mode) begin
						state <= SMC_SLEEP;
						mode  <= i_sleep_mode_select;
					end
				end
				SMC_SLEEP: if (wake_req) state <= SMC_WAKE;
				SMC_WAKE:  if (cnt == '0) state <= SMC_HOLD;
				SMC_HOLD:  if (cnt == '0) state <= SMC_RUN;
			endcase
		end
	end

	// Shared wait counter
	always_comb begin
		next_cnt = cnt;
		if (state == SMC_SLEEP && wake_req) begin
			next_cnt = wake_len - CNT_W'(1);
		end else if (state == SMC_WAKE && cnt == '0) begin
			next_cnt = CNT_W'(SMC_IRQ_HOLD_CYC - 1);
		end else if (cnt != '0) begin
			next_cnt = cnt - CNT_W'(1);
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cnt <= '0;
		end else if (i_core_reset) begin
			cnt <= '0;
		end else begin
			cnt <= next_cnt;
		end
	end

	// ---------------------------------------------------------------
	// Brown-out sleep-disable timed sequence
	// ---------------------------------------------------------------
	// Unlock window opens on a write with both bits set
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			unlock_cnt <= '0;
		end else if (i_mcu_control_register_wr && i_brownout_sleep_disable && i_brownout_disable_unlock) begin
			unlock_cnt <= 3'(SMC_UNLOCK_CYC);
		end else if (unlock_cnt != '0) begin
			unlock_cnt <= unlock_cnt - 3'(1);
		end
	end

	assign brownout_sleep_disable_set = i_mcu_control_register_wr && i_brownout_sleep_disable && !i_brownout_disable_unlock
		&& unlock_cnt != '0;

	// Age counter: active after three cycles, self-clears three later
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			brownout_sleep_disable_age <= '0;
		end else if (brownout_sleep_disable_set) begin
			brownout_sleep_disable_age <= 3'(SMC_BROWNOUT_SLEEP_DISABLE_DELAY_CYC + SMC_BROWNOUT_SLEEP_DISABLE_LIFE_CYC);
		end else if (brownout_sleep_disable_age != '0) begin
			brownout_sleep_disable_age <= brownout_sleep_disable_age - 3'(1);
		end
	end

	assign brownout_sleep_disable_active = (brownout_sleep_disable_age != '0) && (brownout_sleep_disable_age <= 3'(SMC_BROWNOUT_SLEEP_DISABLE_LIFE_CYC));

	// Visible bit reflects active window, reset zero
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_brownout_sleep_disable <= SMC_BROWNOUT_SLEEP_DISABLE_RESET;
		end else begin
			o_brownout_sleep_disable <= brownout_sleep_disable_active;
		end
	end

	// Detector off only from a deep-mode entry during the active window
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			bod_off <= 1'b0;
		end else if (i_core_reset || state == SMC_HOLD) begin
			bod_off <= 1'b0;
		end else if (state == SMC_RUN && i_halt_exec && i_sleep_enable_bit && valid_mode
			&& brownout_sleep_disable_active && i_sleep_mode_select[1]) begin
			bod_off <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// Clock domain and oscillator gating
	// ---------------------------------------------------------------
	// Memory contents are untouched: only clocks are gated
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_clk_cpu_en   <= 1'b1;
			o_clk_flash_en <= 1'b1;
			o_clk_io_en    <= 1'b1;
			o_clk_adc_en   <= 1'b1;
			o_async_timer_clock_en   <= 1'b1;
			o_main_osc_en  <= 1'b1;
			o_timer_osc_en <= 1'b1;
		end else if (state != SMC_SLEEP) begin
			o_clk_cpu_en   <= state == SMC_RUN;
			o_clk_flash_en <= state == SMC_RUN;
			o_clk_io_en    <= 1'b1;
			o_clk_adc_en   <= 1'b1;
			o_async_timer_clock_en   <= 1'b1;
			o_main_osc_en  <= 1'b1;
			o_timer_osc_en <= i_t2_async;
		end else begin
			o_clk_cpu_en   <= 1'b0;
			o_clk_flash_en <= 1'b0;
			o_clk_io_en    <= mode == SMC_MODE_IDLE;
			o_clk_adc_en   <= !deep;
			unique case (mode)
				SMC_MODE_IDLE, SMC_MODE_ADCNR: begin
					o_async_timer_clock_en   <= 1'b1;
					o_main_osc_en  <= 1'b1;
					o_timer_osc_en <= i_t2_async;
				end
				SMC_MODE_PSAVE: begin
					o_async_timer_clock_en   <= i_t2_enable;
					o_main_osc_en  <= i_t2_enable && !i_t2_async;
					o_timer_osc_en <= i_t2_enable && i_t2_async;
				end
				SMC_MODE_XSTBY: begin
					o_async_timer_clock_en   <= i_t2_async;
					o_main_osc_en  <= 1'b1;
					o_timer_osc_en <= i_t2_async;
				end
				SMC_MODE_STANDBY: begin
					o_async_timer_clock_en   <= 1'b0;
					o_main_osc_en  <= 1'b1;
					o_timer_osc_en <= 1'b0;
				end
				default: begin
					o_async_timer_clock_en   <= 1'b0;
					o_main_osc_en  <= 1'b0;
					o_timer_osc_en <= 1'b0;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Status and event outputs
	// ---------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_sleeping             <= 1'b0;
			o_core_hold            <= 1'b0;
			o_brownout_detector_en <= 1'b1;
			o_adc_start            <= 1'b0;
			o_resume_irq           <= 1'b0;
			o_reset_vector         <= 1'b0;
		end else begin
			o_sleeping             <= state == SMC_SLEEP && !i_core_reset;
			o_core_hold            <= (state == SMC_WAKE || state == SMC_HOLD) && !i_core_reset;
			o_brownout_detector_en <= !(bod_off && state == SMC_SLEEP);
			o_adc_start            <= state == SMC_RUN && i_halt_exec && i_sleep_enable_bit
				&& i_adc_enable && !i_sleep_mode_select[2] && !i_sleep_mode_select[1];
			o_resume_irq           <= state == SMC_HOLD && cnt == '0 && !i_core_reset;
			o_reset_vector         <= i_core_reset && state != SMC_RUN;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	sequence s_enter;
		state == SMC_RUN && i_halt_exec && i_sleep_enable_bit && valid_mode && !i_core_reset;
	endsequence

	a_sleep_entry: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		s_enter |=> state == SMC_SLEEP ##1 o_sleeping)
		else $error("sleep not entered");
	a_no_enable: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(state == SMC_RUN && !i_sleep_enable_bit && !i_core_reset) |=> state == SMC_RUN)
		else $error("slept without enable");
	a_reserved_code: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(state == SMC_RUN && i_sleep_mode_select[2:1] == 2'b10 && !i_core_reset)
		|=> state == SMC_RUN)
		else $error("reserved code slept");
	a_hold_four: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(state == SMC_WAKE && cnt == '0 && !i_core_reset) |=>
		(state == SMC_HOLD && !i_core_reset) [*4] |-> ##1 o_resume_irq)
		else $error("hold not four cycles");
	a_reset_wake: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(i_core_reset && state == SMC_SLEEP) |=> state == SMC_RUN && o_reset_vector)
		else $error("reset did not wake");
	a_standby_six: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(state == SMC_SLEEP && wake_req && mode == SMC_MODE_STANDBY && !bod_off
		&& !i_core_reset) ##1 !i_core_reset [*6] |=> state == SMC_HOLD)
		else $error("standby wake not six");
	a_pdown_clocks: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(state == SMC_SLEEP && mode == SMC_MODE_PDOWN) |=> !o_main_osc_en && !o_clk_io_en)
		else $error("power-down clock running");
	a_brownout_sleep_disable_timing: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		brownout_sleep_disable_set |=> !brownout_sleep_disable_active [*3] ##1 brownout_sleep_disable_active)
		else $error("disable bit timing");
	a_bod_shallow: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(state == SMC_SLEEP && !deep) |-> !bod_off)
		else $error("detector off in shallow mode");
	a_bod_back: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(state == SMC_HOLD) |=> o_brownout_detector_en)
		else $error("detector not back on");
endmodule // smc_sleep_ctrl
`default_nettype wire

/* hdl/smc_sync.sv */
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ns
`default_nettype none
module smc_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_reset_n,
	// Data
	input  wire logic [W-1:0] i_async,
	output var  logic [W-1:0] o_sync
);
	logic [W-1:0] stage1;
	logic [W-1:0] stage2;
	logic [W-1:0] stage3;

	// ---------------------------------------------------------------
	// Chain; first stage feeds only the second
	// ---------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
		end else begin
			stage1 <= i_async;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// Output follows only where stages two and three agree
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_sync <= '0;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (stage2[i] == stage3[i]) begin
					o_sync[i] <= stage3[i];
				end
			end
		end
	end
endmodule // smc_sync
`default_nettype wire

/* verif/tb.sv */
// Self-checking testbench for the sleep-mode controller
`timescale 1ns/1ns
`default_nettype none
module tb;
	import smc_pkg::*;
	// ----------------------------------------------------------------
	// Stimulus, observation and counters
	// ----------------------------------------------------------------
	logic             clk, rst_n, halt, se, crw, brownout_sleep_disable, unlk, xtal, adce, t2e, t2a, gie;
	logic             creset, irq0, irq1, pch, twi, wdt, adcd, spm, oth;
	logic [2:0]       sm;
	logic [1:0]       mask, lvl, t2ev;
	logic [15:0]      start;
	logic             slp, hold, cpu, fla, io, adc, asy, mosc, tosc, bod_en, brownout_sleep_disable_o, adcs, res, rv;
	logic [6:0]       gates;
	int               error_cnt, n_tests, cyc, n;
	logic [2:0]       modes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
	logic [6:0]       g_exp [6] = '{7'h1F, 7'h0F, 7'h00, 7'h05, 7'h02, 7'h07};
	int               h_exp [6] = '{5, 5, 24, 24, 10, 10};
	assign gates = {cpu, fla, io, adc, asy, mosc, tosc};

	smc_sleep_ctrl u_dut (
		.i_clk(clk), .i_reset_n(rst_n), .i_halt_exec(halt), .i_sleep_enable_bit(se),
		.i_sleep_mode_select(sm), .i_core_reset(creset), .i_mcu_control_register_wr(crw),
		.i_brownout_sleep_disable(brownout_sleep_disable), .i_brownout_disable_unlock(unlk),
		.i_ext_crystal(xtal), .i_startup_cycles(start), .i_adc_enable(adce),
		.i_t2_enable(t2e), .i_t2_async(t2a), .i_global_irq_enable(gie),
		.i_timer2_irq_mask(mask), .i_external_irq_zero(irq0), .i_external_irq_one(irq1),
		.i_ext_irq_level_mode(lvl), .i_pin_change(pch), .i_twi_match(twi), .i_wdt_irq(wdt),
		.i_adc_done(adcd), .i_spm_ready(spm), .i_timer2_event(t2ev), .i_other_irq(oth),
		.o_sleeping(slp), .o_core_hold(hold), .o_clk_cpu_en(cpu), .o_clk_flash_en(fla),
		.o_clk_io_en(io), .o_clk_adc_en(adc), .o_async_timer_clock_en(asy), .o_main_osc_en(mosc),
		.o_timer_osc_en(tosc), .o_brownout_detector_en(bod_en),
		.o_brownout_sleep_disable(brownout_sleep_disable_o), .o_adc_start(adcs), .o_resume_irq(res),
		.o_reset_vector(rv)
	);

	// ----------------------------------------------------------------
	// Clock and hang guard
	// ----------------------------------------------------------------
	always #50 clk = ~clk;
	// Ceiling well above the longest path (one 600-cycle wake plus entries)
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			report_and_stop();
		end
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		$display("Checks %0d, mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Halt pulse with a given mode and enable; counts converter starts after it
	task automatic do_halt(input logic [2:0] mode, input logic s);
		@(posedge clk);
		sm   <= mode;
		se   <= s;
		halt <= 1'b1;
		@(posedge clk);
		halt <= 1'b0;
		// Start pulse stands in the cycle right after the halt edge
		#1 n = int'(adcs);
		repeat (3) begin
			@(posedge clk);
			#1 n += int'(adcs);
		end
	endtask

	// Waits for the resume pulse and counts cycles of core hold after sleep ends
	task automatic wait_resume(input int exp);
		int k;
		k = 0;
		for (int i = 0; i < 3000; i++) begin
			@(posedge clk);
			#1;
			// Last hold cycle stands alongside the resume pulse
			if (hold === 1'b1 && slp !== 1'b1)
				k++;
			if (res === 1'b1)
				break;
		end
		check("resume_pulse", 16'(res), 16'h1);
		check("hold_cycles", 16'(k), 16'(exp));
		@(posedge clk);
		{wdt, twi, pch, irq0, adcd, spm, oth, t2ev} <= '0;
	endtask

	// Timed two-write unlock of the brown-out disable bit
	task automatic bod_seq(input logic unlock_first);
		@(posedge clk);
		crw  <= 1'b1;
		brownout_sleep_disable <= 1'b1;
		unlk <= unlock_first;
		@(posedge clk);
		unlk <= 1'b0;
		@(posedge clk);
		crw  <= 1'b0;
		brownout_sleep_disable <= 1'b0;
		repeat (2) @(posedge clk);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{clk, rst_n, halt, se, crw, brownout_sleep_disable, unlk, creset, irq0, irq1, pch, twi, wdt} = '0;
		{adcd, spm, oth, sm, mask, lvl, t2ev} = '0;
		{xtal, adce, t2e, t2a, gie} = 5'h1F;
		start = 16'h0014;
		error_cnt = 0;
		n_tests = 0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		check("reset_gates", 16'(gates), 16'h007F);
		check("reset_bod_on", 16'(bod_en), 16'h1);
		check("reset_brownout_sleep_disable", 16'(brownout_sleep_disable_o), 16'(SMC_BROWNOUT_SLEEP_DISABLE_RESET));
		check("reset_sleeping", 16'(slp), 16'h0);
		// Refused halts: no enable, reserved codes, standby codes without crystal
		do_halt(SMC_MODE_IDLE, 1'b0);
		check("no_enable", 16'(slp), 16'h0);
		do_halt(SMC_MODE_RSVD4, 1'b1);
		check("rsvd4", 16'(slp), 16'h0);
		do_halt(SMC_MODE_RSVD5, 1'b1);
		check("rsvd5", 16'(slp), 16'h0);
		xtal <= 1'b0;
		do_halt(SMC_MODE_STANDBY, 1'b1);
		check("stby_no_xtal", 16'(slp), 16'h0);
		do_halt(SMC_MODE_XSTBY, 1'b1);
		check("xstby_no_xtal", 16'(slp), 16'h0);
		xtal <= 1'b1;
		// Every valid mode: gating, converter start, wake length
		for (int m = 0; m < 6; m++) begin
			do_halt(modes[m], 1'b1);
			check("sleeping", 16'(slp), 16'h1);
			check("gates", 16'(gates), 16'(g_exp[m]));
			check("adc_start", 16'(n), (m < 2) ? 16'h1 : 16'h0);
			check("bod_kept", 16'(bod_en), 16'h1);
			@(posedge clk);
			// Watchdog, address match and pin change each take a turn as waker
			{pch, twi, wdt} <= (m < 2) ? 3'h1 : (m < 4) ? 3'h2 : 3'h4;
			wait_resume(h_exp[m]);
		end
		// Power-down ignores sources outside its list and edge-mode pins
		do_halt(SMC_MODE_PDOWN, 1'b1);
		@(posedge clk);
		{adcd, spm, oth, irq0} <= 4'hF;
		t2ev <= 2'h3;
		mask <= 2'h3;
		repeat (12) @(posedge clk);
		#1 check("pdown_refuse", 16'(slp), 16'h1);
		@(posedge clk);
		lvl <= 2'h1;
		wait_resume(24);
		lvl <= 2'h0;
		// Power-save timer wake needs both mask and global enable
		do_halt(SMC_MODE_PSAVE, 1'b1);
		@(posedge clk);
		mask <= 2'h0;
		t2ev <= 2'h3;
		repeat (8) @(posedge clk);
		#1 check("t2_no_mask", 16'(slp), 16'h1);
		@(posedge clk);
		mask <= 2'h3;
		gie  <= 1'b0;
		repeat (8) @(posedge clk);
		#1 check("t2_no_gie", 16'(slp), 16'h1);
		@(posedge clk);
		gie <= 1'b1;
		wait_resume(24);
		// ADC noise mode woken by conversion complete
		do_halt(SMC_MODE_ADCNR, 1'b1);
		@(posedge clk);
		adcd <= 1'b1;
		wait_resume(5);
		// Reset while sleeping goes to the reset vector, not resume
		do_halt(SMC_MODE_PDOWN, 1'b1);
		@(posedge clk);
		creset <= 1'b1;
		n = 0;
		repeat (4) begin
			@(posedge clk);
			#1 n += int'(rv) + 16 * int'(res);
		end
		check("reset_vector", 16'(n), 16'h1);
		check("reset_wakes", 16'(slp), 16'h0);
		@(posedge clk);
		creset <= 1'b0;
		// Disable bit: no effect without unlock, three-cycle window with it
		bod_seq(1'b0);
		n = 0;
		repeat (10) begin
			@(posedge clk);
			#1 n += int'(brownout_sleep_disable_o);
		end
		check("brownout_sleep_disable_locked", 16'(n), 16'h0);
		bod_seq(1'b1);
		n = 0;
		repeat (10) begin
			@(posedge clk);
			#1 n += int'(brownout_sleep_disable_o);
		end
		check("brownout_sleep_disable_window", 16'(n), 16'(SMC_BROWNOUT_SLEEP_DISABLE_LIFE_CYC));
		// Halt inside the window: detector off in deep mode, long wake
		bod_seq(1'b1);
		do_halt(SMC_MODE_PDOWN, 1'b1);
		check("bod_off", 16'(bod_en), 16'h0);
		@(posedge clk);
		wdt <= 1'b1;
		wait_resume(SMC_BOD_WAKE_CYC + SMC_IRQ_HOLD_CYC);
		#1 check("bod_back", 16'(bod_en), 16'h1);
		// Same sequence in Idle leaves the detector running
		bod_seq(1'b1);
		do_halt(SMC_MODE_IDLE, 1'b1);
		check("bod_idle", 16'(bod_en), 16'h1);
		@(posedge clk);
		wdt <= 1'b1;
		wait_resume(5);
		report_and_stop();
	end
endmodule // tb
`default_nettype wire
